// ==== icma_dev_model.sv ====
// Behavioural model of the eight peripheral devices on the channels
`timescale 1ns/100ps
module icma_dev_model #(
  parameter int FAST = 2,
  parameter int SLOW = 24
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  dev_start,
  input  wire logic [7:0]  dev_strobe,
  input  wire logic [7:0]  dev_wdata,
  output logic      [7:0]  dev_ready,
  output logic      [63:0] dev_rdata
);
  int         wait_q [8];
  logic [7:0] char_q [8];
  // A busy device shows the inverted char, so a stale sample is caught
  always_comb
    for (int s = 0; s < 8; s++)
      dev_rdata[8*s +: 8] = dev_ready[s] ? char_q[s] : ~char_q[s];
  always @(posedge core_clk)
    for (int s = 0; s < 8; s++)
      if (!rst_n)
      begin
        dev_ready[s] <= 1'b0;
        wait_q[s]    <= 0;
        char_q[s]    <= 8'h30 + 8'(16 * s);
      end
      else if (dev_start[s] || dev_strobe[s])
      begin
        // Slow devices stay busy far longer than one bus transfer
        dev_ready[s] <= 1'b0;
        wait_q[s]    <= (s < 3) ? FAST : SLOW + 3 * s;
        char_q[s]    <= char_q[s] + 8'(dev_strobe[s]);
      end
      else if (wait_q[s] == 1)
      begin
        dev_ready[s] <= 1'b1;
        wait_q[s]    <= 0;
      end
      else if (wait_q[s] > 1)
        wait_q[s] <= wait_q[s] - 1;
endmodule // icma_dev_model

// ==== icma_io_channel.sv ====
// I/O converter with order-sequence channels, memory priority and core memory
// What this block does
// - Processor, converters share one memory bus
// - Priority logic grants memory to one requester
// - 18-bit address, bit 17 selects registers
// - Accept commands from processor or off-line panel
// - Signal processor only on completion
// - Fetch consecutive I/O orders from memory
// - Channel control words kept in core memory
// - Three high-speed, one shared low-speed channel
// - Low-speed: one character, then release bus
// - Next character only after device ready
// - High-speed channel stays locked to device
// - Three high-speed, five low-speed run concurrently
// - Off-line commands interleaved with on-line ones
// - Reserved device refuses off-line commands
// - Memory counts fields during an access
// - 16K-word memory, two microsecond cycle
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
module icma_sync #(
  parameter int W = 8
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge core_clk)
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end
    else if (clk_en)
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= (agree & s2_q) | (~agree & q);
    end
endmodule // icma_sync

////////////////////////////////////////////////////////////////////////
module icma_io_channel #(
  parameter int WORD_W     = icma_pkg::WORD_W_DEF,
  parameter int MEM_WORDS  = icma_pkg::MEM_WORDS,
  parameter int MEM_CYCLES = icma_pkg::MEM_CYCLES
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  input  wire logic                       cpu_req,
  input  wire logic [icma_pkg::ADDR_W-1:0] cpu_addr,
  input  wire logic [1:0]                 cpu_op,
  input  wire logic [WORD_W-1:0]          cpu_wdata,
  output logic                            cpu_ack,
  input  wire logic                       comm_req,
  input  wire logic [icma_pkg::ADDR_W-1:0] comm_addr,
  input  wire logic [1:0]                 comm_op,
  input  wire logic [WORD_W-1:0]          comm_wdata,
  output logic                            comm_ack,
  output logic      [WORD_W-1:0]          mem_rdata,
  output logic                            reg_stb,
  output logic                            reg_we,
  output logic      [icma_pkg::MADDR_W-1:0] reg_addr,
  output logic      [WORD_W-1:0]          reg_wdata,
  input  wire logic [WORD_W-1:0]          reg_rdata,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire logic [2:0]                 cmd_slot,
  input  wire logic [icma_pkg::MADDR_W-1:0] cmd_ptr,
  input  wire logic                       cmd_out,
  input  wire logic                       ofl_valid,
  output logic                            ofl_ready,
  input  wire logic [2:0]                 ofl_slot,
  input  wire logic [icma_pkg::MADDR_W-1:0] ofl_ptr,
  input  wire logic                       ofl_out,
  output logic                            ofl_refused,
  input  wire logic [7:0]                 reserve,
  input  wire logic [7:0]                 dev_ready,
  input  wire logic [63:0]                dev_rdata,
  output logic      [7:0]                 dev_start,
  output logic      [7:0]                 dev_strobe,
  output logic      [7:0]                 dev_wdata,
  output logic                            io_done,
  output logic      [2:0]                 io_done_slot
);
  localparam int NS   = icma_pkg::N_SLOT;
  localparam int CW   = icma_pkg::CHAR_W;
  localparam int MA   = icma_pkg::MADDR_W;
  localparam int CL   = icma_pkg::CNT_LSB;
  localparam int IX_W = $clog2(MEM_WORDS);
  localparam int CY_W = $clog2(MEM_CYCLES + 1);

  if (WORD_W <= CL + 1 || WORD_W < CW)
    $error("WORD_W too narrow for address and count fields");
  if (MEM_WORDS < 2 || MEM_WORDS > (1 << MA) || (MEM_WORDS & (MEM_WORDS - 1)) != 0)
    $error("MEM_WORDS must be a power of two within the address space");
  if (MEM_CYCLES < 2)
    $error("MEM_CYCLES must be at least two");

  // Count access: address field up, count field down, stops at zero count
  function automatic logic [WORD_W-1:0] counted(input logic [WORD_W-1:0] w);
    if (w[WORD_W-1:CL] == '0)
      return w;
    return {w[WORD_W-1:CL] - 1'b1, w[CL-1:0] + 1'b1};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [NS-1:0]    rdy_f;
  logic [NS-1:0]    rdy_prev_q;
  logic [NS-1:0]    res_f;
  logic [NS*CW-1:0] din_f;

  icma_sync #(.W(NS)) u_rdy (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
                             .d(dev_ready), .q(rdy_f));
  icma_sync #(.W(NS)) u_res (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
                             .d(reserve), .q(res_f));
  icma_sync #(.W(NS*CW)) u_din (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
                                .d(dev_rdata), .q(din_f));

  ////////////////////////////////////////////////////////////////////////
  // Memory priority and core memory
  logic [WORD_W-1:0]          mem_q [MEM_WORDS];
  logic                       busy_q;
  logic                       ackd_q;
  logic [CY_W-1:0]            cyc_q;
  icma_pkg::icma_own_type     own_q;
  logic [icma_pkg::ADDR_W-1:0] lat_addr_q;
  logic [1:0]                 lat_op_q;
  logic [WORD_W-1:0]          lat_wdata_q;
  logic [WORD_W-1:0]          rd_q;
  logic [WORD_W-1:0]          rdata_q;
  logic                       eng_req;
  logic [icma_pkg::ADDR_W-1:0] eng_addr;
  logic [1:0]                 eng_op;
  logic [WORD_W-1:0]          eng_wdata;

  wire arb_free   = !busy_q && !ackd_q;
  wire comm_grant = arb_free && comm_req;
  wire eng_grant  = arb_free && !comm_req && eng_req;
  wire cpu_grant  = arb_free && !comm_req && !eng_req && cpu_req;
  wire any_grant  = comm_grant || eng_grant || cpu_grant;
  wire [icma_pkg::ADDR_W-1:0] g_addr = comm_grant ? comm_addr :
                                       eng_grant ? eng_addr : cpu_addr;
  wire [1:0]        g_op    = comm_grant ? comm_op : eng_grant ? eng_op : cpu_op;
  wire [WORD_W-1:0] g_wdata = comm_grant ? comm_wdata : eng_grant ? eng_wdata : cpu_wdata;
  wire g_in_mem   = !g_addr[icma_pkg::REG_SEL] && (32'(g_addr[MA-1:0]) < MEM_WORDS);
  wire lat_in_mem = !lat_addr_q[icma_pkg::REG_SEL]
                    && (32'(lat_addr_q[MA-1:0]) < MEM_WORDS);
  wire finish     = busy_q && (32'(cyc_q) == MEM_CYCLES - 1);
  wire mem_wr     = finish && lat_in_mem && (lat_op_q != icma_pkg::OP_READ);
  wire [WORD_W-1:0] wr_val = (lat_op_q == icma_pkg::OP_COUNT) ? counted(rd_q)
                                                              : lat_wdata_q;
  wire eng_ack    = ackd_q && (own_q == icma_pkg::OWN_IOC);

  assign cpu_ack   = ackd_q && (own_q == icma_pkg::OWN_CPU);
  assign comm_ack  = ackd_q && (own_q == icma_pkg::OWN_COMM);
  assign mem_rdata = rdata_q;
  assign reg_addr  = lat_addr_q[MA-1:0];
  assign reg_wdata = lat_wdata_q;
  assign reg_we    = lat_op_q != icma_pkg::OP_READ;

  always_ff @(posedge core_clk)
    if (clk_en)
    begin
      if (mem_wr)
        mem_q[lat_addr_q[IX_W-1:0]] <= wr_val;
    end

  always_ff @(posedge core_clk)
    if (!rst_n)
    begin
      busy_q      <= 1'b0;
      ackd_q      <= 1'b0;
      cyc_q       <= '0;
      own_q       <= icma_pkg::OWN_NONE;
      lat_addr_q  <= '0;
      lat_op_q    <= icma_pkg::OP_READ;
      lat_wdata_q <= '0;
      rd_q        <= '0;
      rdata_q     <= '0;
      reg_stb     <= 1'b0;
    end
    else if (clk_en)
    begin
      ackd_q  <= finish;
      reg_stb <= any_grant && g_addr[icma_pkg::REG_SEL];
      if (any_grant)
      begin
        busy_q      <= 1'b1;
        cyc_q       <= '0;
        own_q       <= comm_grant ? icma_pkg::OWN_COMM :
                       eng_grant ? icma_pkg::OWN_IOC : icma_pkg::OWN_CPU;
        lat_addr_q  <= g_addr;
        lat_op_q    <= g_op;
        lat_wdata_q <= g_wdata;
        rd_q        <= g_in_mem ? mem_q[g_addr[IX_W-1:0]] : '0;
      end
      else if (finish)
      begin
        busy_q  <= 1'b0;
        rdata_q <= lat_addr_q[icma_pkg::REG_SEL] ? reg_rdata : rd_q;
      end
      else if (busy_q)
        cyc_q <= cyc_q + 1'b1;
    end

  ////////////////////////////////////////////////////////////////////////
  // Channel engine
  icma_pkg::icma_state_type state_q;
  logic [2:0]        slot_q;
  logic [WORD_W-1:0] hold_q;
  logic [NS-1:0]     act_q;
  logic [NS-1:0]     dir_q;
  logic [NS-1:0]     pend_q;
  logic [2:0]        lsrot_q;
  logic              tie_q;
  logic              serve_any;
  logic [2:0]        serve_slot;
  logic [2:0]        ls_pick;
  logic              ls_hit;

  wire [NS-1:0] want = pend_q & act_q;
  wire idle      = state_q == icma_pkg::ST_IDLE;
  wire cnt_zero  = rdata_q[WORD_W-1:CL] == '0;
  wire cpu_turn  = !ofl_valid || !tie_q;
  wire ofl_turn  = !cmd_valid || tie_q;
  wire take_ofl  = ofl_valid && ofl_ready;
  wire ofl_ok    = take_ofl && !res_f[ofl_slot];
  wire [MA-1:0] cw_addr = icma_pkg::CW_BASE + {14'h0000, slot_q};
  wire [MA-1:0] dw_addr = icma_pkg::DW_BASE + {14'h0000, slot_q};
  wire [CW-1:0] din_char = din_f[slot_q*CW +: CW];
  wire slot_clr  = (eng_ack && state_q == icma_pkg::ST_DATA)
                   || (eng_ack && state_q == icma_pkg::ST_ORD && cnt_zero);

  assign cmd_ready = idle && !serve_any && cpu_turn && !act_q[cmd_slot];
  assign ofl_ready = idle && !serve_any && ofl_turn
                     && (!act_q[ofl_slot] || res_f[ofl_slot]);

  // Locked high-speed channels first, then low-speed devices in rotation
  always_comb
  begin
    int j;
    j          = 0;
    serve_any  = 1'b0;
    serve_slot = 3'h0;
    ls_pick    = lsrot_q;
    ls_hit     = 1'b0;
    for (int i = icma_pkg::N_HS - 1; i >= 0; i--)
      if (want[i])
      begin
        serve_any  = 1'b1;
        serve_slot = 3'(i);
      end
    for (int k = 1; k <= icma_pkg::N_LS; k++)
    begin
      j = (int'(lsrot_q) + k) % icma_pkg::N_LS;
      if (!serve_any && !ls_hit && want[icma_pkg::N_HS + j])
      begin
        ls_hit     = 1'b1;
        serve_slot = 3'(icma_pkg::N_HS + j);
        ls_pick    = 3'(j);
      end
    end
    serve_any = serve_any || ls_hit;
  end

  always_comb
  begin
    eng_req   = 1'b1;
    eng_addr  = '0;
    eng_op    = icma_pkg::OP_READ;
    eng_wdata = hold_q;
    case (state_q)
      icma_pkg::ST_CMDW:
      begin
        eng_addr = {1'b0, cw_addr};
        eng_op   = icma_pkg::OP_WRITE;
      end
      icma_pkg::ST_CWR:
      begin
        eng_addr = {1'b0, cw_addr};
        eng_op   = icma_pkg::OP_COUNT;
      end
      icma_pkg::ST_ORD:  eng_addr = {1'b0, hold_q[MA-1:0]};
      icma_pkg::ST_DWW:
      begin
        eng_addr = {1'b0, dw_addr};
        eng_op   = icma_pkg::OP_WRITE;
      end
      icma_pkg::ST_DWR:
      begin
        eng_addr = {1'b0, dw_addr};
        eng_op   = icma_pkg::OP_COUNT;
      end
      icma_pkg::ST_DATA:
      begin
        eng_addr  = {1'b0, hold_q[MA-1:0]};
        eng_op    = dir_q[slot_q] ? icma_pkg::OP_READ : icma_pkg::OP_WRITE;
        eng_wdata = {{(WORD_W-CW){1'b0}}, din_char};
      end
      default:           eng_req = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk)
    if (!rst_n)
      rdy_prev_q <= '0;
    else if (clk_en)
      rdy_prev_q <= rdy_f;

  always_ff @(posedge core_clk)
    if (!rst_n)
    begin
      state_q      <= icma_pkg::ST_IDLE;
      slot_q       <= 3'h0;
      hold_q       <= '0;
      act_q        <= '0;
      dir_q        <= '0;
      pend_q       <= '0;
      lsrot_q      <= 3'h0;
      tie_q        <= 1'b0;
      ofl_refused  <= 1'b0;
      dev_start    <= '0;
      dev_strobe   <= '0;
      dev_wdata    <= '0;
      io_done      <= 1'b0;
      io_done_slot <= 3'h0;
    end
    else if (clk_en)
    begin
      // A ready edge in the clearing cycle still counts
      pend_q      <= (rdy_f & ~rdy_prev_q)
                     | (pend_q & ~(slot_clr ? NS'(1) << slot_q : '0));
      ofl_refused <= take_ofl && res_f[ofl_slot];
      dev_start   <= '0;
      dev_strobe  <= '0;
      io_done     <= 1'b0;
      case (state_q)
        icma_pkg::ST_IDLE:
          if (serve_any)
          begin
            slot_q  <= serve_slot;
            state_q <= icma_pkg::ST_DWR;
            if (ls_hit)
              lsrot_q <= ls_pick;
          end
          else if (cmd_valid && cmd_ready)
          begin
            slot_q         <= cmd_slot;
            // A full count field lets each CW count step to the next order
            hold_q         <= {{(WORD_W-MA){1'b1}}, cmd_ptr};
            dir_q[cmd_slot] <= cmd_out;
            tie_q          <= 1'b1;
            state_q        <= icma_pkg::ST_CMDW;
          end
          else if (ofl_ok)
          begin
            slot_q         <= ofl_slot;
            hold_q         <= {{(WORD_W-MA){1'b1}}, ofl_ptr};
            dir_q[ofl_slot] <= ofl_out;
            tie_q          <= 1'b0;
            state_q        <= icma_pkg::ST_CMDW;
          end
        icma_pkg::ST_CMDW:
          if (eng_ack)
          begin
            act_q[slot_q] <= 1'b1;
            state_q       <= icma_pkg::ST_CWR;
          end
        icma_pkg::ST_CWR:
          if (eng_ack)
          begin
            hold_q  <= rdata_q;
            state_q <= icma_pkg::ST_ORD;
          end
        icma_pkg::ST_ORD:
          if (eng_ack)
          begin
            hold_q <= rdata_q;
            if (cnt_zero)
            begin
              // Zero-count order ends the sequence
              act_q[slot_q] <= 1'b0;
              io_done       <= 1'b1;
              io_done_slot  <= slot_q;
              state_q       <= icma_pkg::ST_IDLE;
            end
            else
              state_q <= icma_pkg::ST_DWW;
          end
        icma_pkg::ST_DWW:
          if (eng_ack)
            state_q <= pend_q[slot_q] ? icma_pkg::ST_DWR : icma_pkg::ST_START;
        icma_pkg::ST_START:
        begin
          dev_start[slot_q] <= 1'b1;
          state_q           <= icma_pkg::ST_IDLE;
        end
        icma_pkg::ST_DWR:
          if (eng_ack)
          begin
            hold_q  <= rdata_q;
            state_q <= cnt_zero ? icma_pkg::ST_CWR : icma_pkg::ST_DATA;
          end
        icma_pkg::ST_DATA:
          if (eng_ack)
          begin
            // One character per ready, then the bus goes back to others
            dev_strobe[slot_q] <= 1'b1;
            if (dir_q[slot_q])
              dev_wdata <= rdata_q[CW-1:0];
            state_q <= icma_pkg::ST_IDLE;
          end
        default: state_q <= icma_pkg::ST_IDLE;
      endcase
    end
endmodule // icma_io_channel

// ==== icma_io_channel_bench.sv ====
// Self-checking bench for the I/O channel memory access block
`timescale 1ns/100ps
module icma_io_channel_bench;
  logic        core_clk, rst_n, cpu_req, cpu_ack, comm_req, comm_ack, reg_stb, reg_we;
  logic        cmd_valid, cmd_ready, cmd_out, ofl_valid, ofl_ready, ofl_out, ofl_refused;
  logic        io_done, rs_we, refused;
  logic [1:0]  cpu_op, comm_op;
  logic [2:0]  cmd_slot, ofl_slot, io_done_slot, done_slot;
  logic [7:0]  reserve, dev_ready, dev_start, dev_strobe, dev_wdata, armed, rdy_q, started;
  logic [16:0] reg_addr, cmd_ptr, ofl_ptr, rs_addr;
  logic [17:0] cpu_addr, comm_addr;
  logic [31:0] cpu_wdata, comm_wdata, mem_rdata, reg_wdata, reg_rdata, rs_wdata, tmp;
  logic [63:0] dev_rdata;
  logic [7:0]  sq [8][$];
  int          failures, compares, done_cnt;

  icma_io_channel #(.MEM_CYCLES(4)) u_icma_io_channel (
    .core_clk, .rst_n, .clk_en(1'b1), .cpu_req, .cpu_addr, .cpu_op, .cpu_wdata, .cpu_ack,
    .comm_req, .comm_addr, .comm_op, .comm_wdata, .comm_ack, .mem_rdata, .reg_stb, .reg_we,
    .reg_addr, .reg_wdata, .reg_rdata, .cmd_valid, .cmd_ready, .cmd_slot, .cmd_ptr, .cmd_out,
    .ofl_valid, .ofl_ready, .ofl_slot, .ofl_ptr, .ofl_out, .ofl_refused, .reserve,
    .dev_ready, .dev_rdata, .dev_start, .dev_strobe, .dev_wdata, .io_done, .io_done_slot);
  icma_dev_model u_icma_dev_model (.core_clk, .rst_n, .dev_start, .dev_strobe, .dev_wdata,
    .dev_ready, .dev_rdata);
  assign reg_rdata = {15'h0, reg_addr} ^ 32'h3c000000;

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  ////////////////////////////////////////
  always @(posedge core_clk)
  begin
    rdy_q <= dev_ready;
    armed <= rst_n ? (armed | (dev_ready & ~rdy_q)) & ~dev_strobe : 8'h00;
    started <= rst_n ? (started | dev_start) : 8'h00;
    if (reg_stb === 1'b1)
      {rs_we, rs_addr, rs_wdata} <= {reg_we, reg_addr, reg_wdata};
    if (ofl_refused === 1'b1)
      refused <= 1'b1;
    if (io_done === 1'b1)
      done_slot <= io_done_slot;
    done_cnt <= done_cnt + int'(io_done === 1'b1);
    for (int s = 0; s < 8; s++)
      if (dev_strobe[s] === 1'b1)
      begin
        sq[s].push_back(dev_wdata);
        if (s > 2 && armed[s] !== 1'b1)
          fail("strobe before ready");
      end
  end
  ////////////////////////////////////////
  task automatic fail(input string m);
    failures++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e)
      fail($sformatf("%s got %h exp %h", m, g, e));
  endtask
  task automatic end_of_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic mem_op(input bit c, input logic [1:0] op, input logic [17:0] a,
                        input logic [31:0] wd, output logic [31:0] r);
    int n;
    @(negedge core_clk);
    if (c)
      {comm_req, comm_op, comm_addr, comm_wdata} = {1'b1, op, a, wd};
    else
      {cpu_req, cpu_op, cpu_addr, cpu_wdata} = {1'b1, op, a, wd};
    for (n = 0; n < 300; n++)
    begin
      @(negedge core_clk);
      if ((c ? comm_ack : cpu_ack) === 1'b1)
        break;
    end
    if (n == 300)
      begin fail("no ack"); end_of_test(); end
    r = mem_rdata;
    @(negedge core_clk);
    if (c)
      comm_req = 1'b0;
    else
      cpu_req = 1'b0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    mem_op(1'b0, icma_pkg::OP_WRITE, a, d, tmp);
  endtask
  task automatic rd(input logic [17:0] a, output logic [31:0] r);
    mem_op(1'b0, icma_pkg::OP_READ, a, 32'h0, r);
  endtask
  task automatic cmd(input bit off, input logic [2:0] s, input logic [16:0] p, input logic o);
    int n;
    @(negedge core_clk);
    if (off)
      {ofl_valid, ofl_slot, ofl_ptr, ofl_out} = {1'b1, s, p, o};
    else
      {cmd_valid, cmd_slot, cmd_ptr, cmd_out} = {1'b1, s, p, o};
    for (n = 0; n < 2000 && (off ? ofl_ready : cmd_ready) !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 2000)
      begin fail("command not taken"); end_of_test(); end
    @(negedge core_clk);
    {ofl_valid, cmd_valid} = 2'b00;
  endtask
  task automatic wait_done(input int n);
    for (int i = 0; i < 3000 && done_cnt < n; i++)
      @(negedge core_clk);
    if (done_cnt < n)
      begin fail("no completion"); end_of_test(); end
  endtask
  ////////////////////////////////////////
  task automatic t_memory;
    logic [31:0] r, r2;
    time         tc, tm;
    wr(18'h00100, {15'd2, 17'h00040});
    mem_op(1'b0, icma_pkg::OP_COUNT, 18'h00100, 32'h0, r);
    chk(r, {15'd2, 17'h00040}, "count old");
    rd(18'h00100, r);
    chk(r, {15'd1, 17'h00041}, "count new");
    wr(18'h00101, 32'h00000007);
    mem_op(1'b0, icma_pkg::OP_COUNT, 18'h00101, 32'h0, r);
    rd(18'h00101, r);
    chk(r, 32'h00000007, "zero count");
    wr(18'h04000, 32'h12345678);
    rd(18'h04000, r);
    chk(r, 32'h0, "past end");
    wr(18'h20005, 32'hcafe0001);
    chk({14'h0, rs_we, rs_addr}, 32'h00020005, "reg write");
    chk(rs_wdata, 32'hcafe0001, "reg data");
    rd(18'h2000a, r);
    chk(r, 32'h3c00000a, "reg read");
    fork
      begin
        mem_op(1'b0, icma_pkg::OP_WRITE, 18'h00110, 32'h11, r);
        tc = $time;
      end
      begin
        mem_op(1'b1, icma_pkg::OP_WRITE, 18'h00110, 32'h22, r2);
        tm = $time;
      end
    join
    chk(32'(tm < tc), 32'h1, "grant order");
    rd(18'h00110, r);
    chk(r, 32'h11, "last writer");
  endtask
  task automatic t_hs_out;
    int n0;
    wr(18'h00200, {15'd3, 17'h00300});
    wr(18'h00201, 32'h0);
    for (int i = 0; i < 3; i++)
      wr(18'h00300 + 18'(i), 32'hff0000a1 + i);
    n0 = done_cnt;
    cmd(1'b0, 3'd0, 17'h00200, 1'b1);
    wait_done(n0 + 1);
    chk(done_slot, 3'd0, "done slot");
    chk(started, 8'h01, "started");
    chk(sq[0].size(), 3, "char count");
    for (int i = 0; i < 3; i++)
      chk(sq[0][i], 32'ha1 + i, "out char");
  endtask
  task automatic t_ls_mix;
    int          n0;
    logic [31:0] r;
    wr(18'h00240, {15'd2, 17'h00400});
    wr(18'h00241, 32'h0);
    wr(18'h00250, {15'd2, 17'h00500});
    wr(18'h00251, 32'h0);
    wr(18'h00500, 32'h000000b1);
    wr(18'h00501, 32'h000000b2);
    n0 = done_cnt;
    cmd(1'b0, 3'd3, 17'h00240, 1'b0);
    cmd(1'b1, 3'd4, 17'h00250, 1'b1);
    chk(done_cnt, n0, "overlap");
    wait_done(n0 + 2);
    chk(started, 8'h19, "both started");
    for (int i = 0; i < 2; i++)
    begin
      rd(18'h00400 + 18'(i), r);
      chk(r[7:0], 32'h60 + i, "in char");
      chk(sq[4][i], 32'hb1 + i, "ls out char");
    end
  endtask
  task automatic t_reserve;
    int n0;
    @(negedge core_clk);
    reserve = 8'h20;
    refused = 1'b0;
    wr(18'h00270, {15'd1, 17'h00520});
    wr(18'h00271, 32'h0);
    wr(18'h00520, 32'h000000c5);
    n0 = done_cnt;
    cmd(1'b1, 3'd5, 17'h00270, 1'b1);
    repeat (100) @(negedge core_clk);
    chk({refused, started[5]}, 2'b10, "refusal");
    chk(done_cnt, n0, "no run");
    cmd(1'b0, 3'd5, 17'h00270, 1'b1);
    wait_done(n0 + 1);
    chk(done_slot, 3'd5, "online run");
    chk(sq[5][0], 32'hc5, "online char");
  endtask
  ////////////////////////////////////////
  initial
  begin
    {cpu_req, comm_req, cmd_valid, ofl_valid, cmd_out, ofl_out, refused} = '0;
    {cpu_addr, comm_addr, cpu_op, comm_op, cpu_wdata, comm_wdata} = '0;
    {cmd_slot, ofl_slot, cmd_ptr, ofl_ptr, reserve, started} = '0;
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    t_memory();
    t_hs_out();
    t_ls_mix();
    t_reserve();
    end_of_test();
  end
endmodule // icma_io_channel_bench

bind icma_io_channel icma_io_channel_monitor #(.MEM_CYCLES(MEM_CYCLES)) u_icma_io_channel_monitor (
  .core_clk, .rst_n, .cpu_req, .cpu_ack, .comm_req, .comm_ack, .reg_stb, .reg_addr,
  .ofl_valid, .ofl_ready, .ofl_refused, .dev_start, .dev_strobe, .io_done);

// ==== icma_io_channel_monitor.sv ====
// Port checker for the I/O channel memory access block
`timescale 1ns/100ps
module icma_io_channel_monitor #(
  parameter int MEM_CYCLES = 4
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        cpu_req,
  input wire logic        cpu_ack,
  input wire logic        comm_req,
  input wire logic        comm_ack,
  input wire logic        reg_stb,
  input wire logic [16:0] reg_addr,
  input wire logic        ofl_valid,
  input wire logic        ofl_ready,
  input wire logic        ofl_refused,
  input wire logic [7:0]  dev_start,
  input wire logic [7:0]  dev_strobe,
  input wire logic        io_done
);
  localparam int REG_LAT = MEM_CYCLES;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  ack_single_a: assert property (!(cpu_ack && comm_ack))
    else $error("two acks at once");
  ack_gap_a: assert property ((cpu_ack || comm_ack) |=> !(cpu_ack || comm_ack) [*4])
    else $error("memory cycle too short");
  cpu_owner_a: assert property (cpu_ack |-> cpu_req)
    else $error("processor ack without request");
  comm_owner_a: assert property (comm_ack |-> comm_req)
    else $error("converter ack without request");
  reg_lat_a: assert property (reg_stb |-> ##REG_LAT (cpu_ack || comm_ack))
    else $error("register access length wrong");
  reg_hold_a: assert property (reg_stb |=> $stable(reg_addr) [*2])
    else $error("register address moved");
  start_one_a: assert property ($onehot0(dev_start))
    else $error("several devices started");
  strobe_one_a: assert property ($onehot0(dev_strobe))
    else $error("several characters at once");
  refuse_take_a: assert property (ofl_refused |-> $past(ofl_valid) && $past(ofl_ready))
    else $error("refusal without command");
  done_pulse_a: assert property (io_done |=> !io_done)
    else $error("completion longer than one cycle");
endmodule // icma_io_channel_monitor

// ==== icma_pkg.sv ====
// Constants and types shared by the I/O channel memory access block
package icma_pkg;
  localparam int ADDR_W       = 18;
  localparam int MADDR_W      = 17;
  localparam int REG_SEL      = 17;
  localparam int N_HS         = 3;
  localparam int N_LS         = 5;
  localparam int N_SLOT       = 8;
  localparam int SLOT_W       = 3;
  localparam int CHAR_W       = 8;
  localparam int CNT_LSB      = 17;
  localparam int WORD_W_DEF   = 32;
  localparam int MEM_WORDS    = 16384;
  localparam int CLK_NS       = 20;
  localparam int MEM_CYCLE_NS = 2000;
  localparam int MEM_CYCLES   = (MEM_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  // Channel instruction and data control words live in core memory
  localparam logic [MADDR_W-1:0] CW_BASE = 17'h00010;
  localparam logic [MADDR_W-1:0] DW_BASE = 17'h00018;

  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_WRITE = 2'b01,
    OP_COUNT = 2'b10
  } icma_op_type;

  typedef enum logic [1:0] {
    OWN_NONE = 2'b00,
    OWN_IOC  = 2'b01,
    OWN_COMM = 2'b10,
    OWN_CPU  = 2'b11
  } icma_own_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMDW  = 3'b001,
    ST_CWR   = 3'b010,
    ST_ORD   = 3'b011,
    ST_DWW   = 3'b100,
    ST_DWR   = 3'b101,
    ST_DATA  = 3'b110,
    ST_START = 3'b111
  } icma_state_type;
endpackage
